// File: pkg/strap_pkg.sv
// Purpose: Shared constants and types for the radar mode strap sampler.
// Assumes: A 20 MHz system clock and three-comparator sensing of each strap pad.
// Notes: Functional notes follow.
package strap_pkg;

  localparam int CLK_MHZ      = 20;
  localparam int CNT_W        = 17;
  localparam int FUSE_W       = 16;

  // Times in microseconds, cycle counts derived from the clock rate; DEFAULTS_CYC is given directly in cycles.
  localparam int SETTLE_US    = 200;
  localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;
  localparam int PLL_US       = 20;
  localparam int PLL_CYC      = PLL_US * CLK_MHZ;
  localparam int BB_US        = 5000;
  localparam int BB_CYC_DEF   = BB_US * CLK_MHZ;
  localparam int PULSE_ON_US  = 5;
  localparam int PULSE_ON_CYC = PULSE_ON_US * CLK_MHZ;
  localparam int PRP_US       = 500;
  localparam int PRP_CYC_DEF  = PRP_US * CLK_MHZ;
  localparam int DEFAULTS_CYC = 10;

  // Phase accumulator giving 20 MHz * 96 / 200 = 9.6 MHz on average.
  localparam logic [8:0] NCO_STEP = 9'h060;
  localparam logic [8:0] NCO_MOD  = 9'h0C8;
  localparam logic [7:0] NCO_HALF = 8'h64;

  localparam int STATUS_REG     = 56;
  localparam int INIT_DONE_BIT  = 14;
  localparam int SOFT_RESET_REG = 15;

  typedef enum logic [1:0] {
    MODE_CONT_WAVE = 2'h0,
    MODE_PULSED  = 2'h1,
    MODE_SPI_CLK = 2'h2,
    MODE_SPI     = 2'h3
  } op_mode_t;

  localparam op_mode_t MODE_RST = MODE_CONT_WAVE;

  typedef enum logic [2:0] {
    S_START    = 3'h0,
    S_SETTLE   = 3'h1,
    S_CAPTURE  = 3'h2,
    S_DEFAULTS = 3'h3,
    S_PLL      = 3'h4,
    S_BB       = 3'h5,
    S_RUN      = 3'h6
  } init_state_t;

  // Thermometer code from three pad comparators: 000, 001, 011, 111.
  typedef logic [2:0] pad_level_t;

  typedef struct packed {
    pad_level_t freq;
    pad_level_t hold;
    pad_level_t thresh;
    pad_level_t mode;
  } strap_pads_t;

  typedef struct packed {
    logic [1:0] freq;
    logic [1:0] hold;
    logic [1:0] thresh;
    op_mode_t   mode;
  } strap_codes_t;

endpackage

// File: hw/strap_sense.sv
// Purpose: Synchronise strap comparators, fuses and chip select; decode straps.
// Assumes: All inputs are asynchronous pad levels.
// Notes: Codes are combinational from the second sync stage.
module strap_sense (
  input  wire logic                        clk_in,
  input  wire logic                        arst_n_in,
  input  wire strap_pkg::strap_pads_t      pads_in,
  input  wire logic [strap_pkg::FUSE_W-1:0] fuse_in,
  input  wire logic                        cs_n_in,
  output strap_pkg::strap_codes_t          codes_out,
  output logic [strap_pkg::FUSE_W-1:0]     fuse_out,
  output logic                             cs_n_out
);

  localparam int SW = $bits(strap_pkg::strap_pads_t) + strap_pkg::FUSE_W + 1;

  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  strap_pkg::strap_pads_t pads_s;

  // Counting set comparators tolerates a bubble in the thermometer code.
  function automatic logic [1:0] level_code(input strap_pkg::pad_level_t lv);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 0; i < 3; i++) begin
      n = n + {1'b0, lv[i]};
    end
    return n;
  endfunction

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // Both stages reset high so chip select reads idle and no false pause follows reset.
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= {pads_in, fuse_in, cs_n_in};
      sync_q <= meta_q;
    end
  end

  assign pads_s   = sync_q[SW-1 -: $bits(strap_pkg::strap_pads_t)];
  assign fuse_out = sync_q[strap_pkg::FUSE_W:1];
  assign cs_n_out = sync_q[0];

  assign codes_out = '{
    freq:   level_code(pads_s.freq),
    hold:   level_code(pads_s.hold),
    thresh: level_code(pads_s.thresh),
    mode:   strap_pkg::op_mode_t'(level_code(pads_s.mode))
  };

endmodule

// File: hw/pulse_gate.sv
// Purpose: Transmitter gate for autonomous pulsed operation.
// Assumes: Enable and pause come from logic on the same clock.
// Notes: The period count is passed in so simulation can shorten it.
module pulse_gate #(
  parameter int unsigned PRP_CYC = strap_pkg::PRP_CYC_DEF
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic enable_in,
  input  wire logic pause_in,
  output logic      tx_on_out
);

  localparam logic [strap_pkg::CNT_W-1:0] PERIOD_LAST = strap_pkg::CNT_W'(PRP_CYC - 1);
  localparam logic [strap_pkg::CNT_W-1:0] ON_CYC = strap_pkg::CNT_W'(strap_pkg::PULSE_ON_CYC);

  logic [strap_pkg::CNT_W-1:0] cnt_q;
  logic [strap_pkg::CNT_W-1:0] cnt_d;
  logic                        tx_d;
  logic                        tx_q;

  assign cnt_d = !enable_in ? '0 :
                 pause_in ? cnt_q :
                 (cnt_q == PERIOD_LAST) ? '0 : cnt_q + 1'b1;
  // on for the first part of each period
  assign tx_d  = enable_in && (cnt_d < ON_CYC);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= '0;
      tx_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tx_q  <= tx_d;
    end
  end

  assign tx_on_out = tx_q;

  a_pulse_width: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    tx_q |-> enable_in == $past(enable_in) ? cnt_q < ON_CYC : 1'b1)
    else $error("Pulse gate on outside the on window.");

endmodule

// File: hw/radar_mode_strap_sampler.sv
// Purpose: Strap capture, mode selection and init sequencing of the radar controller.
// Assumes: ARST_N_IN combines power-on reset and the reset pin; SOFT_RESET_IN is
//          the soft-reset control bit, synchronous to CLK_SYS_IN.
// Notes: Register writes, PLL and RF control are outside; this block only sequences.
module radar_mode_strap_sampler #(
  parameter int unsigned BB_SETTLE_CYC = strap_pkg::BB_CYC_DEF,
  parameter int unsigned PRP_CYC       = strap_pkg::PRP_CYC_DEF
) (
  input  wire logic                          CLK_SYS_IN,
  input  wire logic                          ARST_N_IN,
  input  wire logic                          SOFT_RESET_IN,
  input  wire logic                          SPI_CS_N_IN,
  input  wire strap_pkg::strap_pads_t        STRAP_PADS_IN,
  input  wire logic [strap_pkg::FUSE_W-1:0]  FUSE_IN,
  output strap_pkg::op_mode_t                MODE_OUT,
  output strap_pkg::strap_codes_t            STRAP_CODES_OUT,
  output logic [strap_pkg::FUSE_W-1:0]       FUSE_OUT,
  output logic                               INIT_DONE_OUT,
  output logic                               SPI_EXT_OWN_OUT,
  output logic                               TX_EN_OUT,
  output logic                               CLK96_OUT
);

  localparam int W = strap_pkg::CNT_W;
  localparam logic [W-1:0] SETTLE_LIM   = W'(strap_pkg::SETTLE_CYC);
  localparam logic [W-1:0] DEFAULTS_LIM = W'(strap_pkg::DEFAULTS_CYC);
  localparam logic [W-1:0] PLL_LIM      = W'(strap_pkg::PLL_CYC);
  localparam logic [W-1:0] BB_LIM       = W'(BB_SETTLE_CYC);

  strap_pkg::init_state_t            state_q;
  strap_pkg::init_state_t            state_d;
  logic [W-1:0]                      cnt_q;
  logic [W-1:0]                      cnt_d;
  strap_pkg::op_mode_t               mode_q;
  strap_pkg::strap_codes_t           codes_q;
  strap_pkg::strap_codes_t           codes_live;
  logic [strap_pkg::FUSE_W-1:0]      fuse_q;
  logic [strap_pkg::FUSE_W-1:0]      fuse_live;
  logic                              init_done_q;
  logic                              spi_own_q;
  logic                              tx_q;
  logic                              tx_d;
  logic [7:0]                        nco_q;
  logic [7:0]                        nco_d;
  logic [8:0]                        nco_sum;
  logic                              clk_q;
  logic                              clk_run;
  logic                              cs_n_s;
  logic                              pause;
  logic                              capture_fire;
  logic                              live_is_spi;
  logic                              leave_defaults;
  logic                              leave_bb;
  logic                              pulse_tx;
  logic                              pulse_en;
  logic                              run_wave;
  logic                              run_pulsed;

  // True on the last cycle of a timed phase, so the count and the state move together.
  function automatic logic expired(input logic [W-1:0] c, input logic [W-1:0] lim);
    return c >= lim - 1'b1;
  endfunction

  strap_sense strap_sense_i (
    .clk_in    (CLK_SYS_IN),
    .arst_n_in (ARST_N_IN),
    .pads_in   (STRAP_PADS_IN),
    .fuse_in   (FUSE_IN),
    .cs_n_in   (SPI_CS_N_IN),
    .codes_out (codes_live),
    .fuse_out  (fuse_live),
    .cs_n_out  (cs_n_s)
  );

  // halt while chip select is low
  assign pause          = !cs_n_s;
  assign capture_fire   = (state_q == strap_pkg::S_CAPTURE) && !pause;
  assign live_is_spi    = codes_live.mode[1];
  assign leave_defaults = (state_q == strap_pkg::S_DEFAULTS) && !pause &&
                          expired(cnt_q, DEFAULTS_LIM);
  assign leave_bb       = (state_q == strap_pkg::S_BB) && !pause && expired(cnt_q, BB_LIM);
  assign run_wave       = (state_q == strap_pkg::S_RUN) &&
                          (mode_q == strap_pkg::MODE_CONT_WAVE);
  assign run_pulsed     = (state_q == strap_pkg::S_RUN) && (mode_q == strap_pkg::MODE_PULSED);
  assign pulse_en       = run_pulsed;

  // Init sequence. Fuses are sampled together with the straps in the capture state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      strap_pkg::S_START: begin
        state_d = strap_pkg::S_SETTLE;
      end
      strap_pkg::S_SETTLE: begin
        if (expired(cnt_q, SETTLE_LIM)) begin
          state_d = strap_pkg::S_CAPTURE;
        end
      end
      // SPI mode skips the rest of init
      strap_pkg::S_CAPTURE: begin
        state_d = live_is_spi ? strap_pkg::S_RUN : strap_pkg::S_DEFAULTS;
      end
      strap_pkg::S_DEFAULTS: begin
        if (expired(cnt_q, DEFAULTS_LIM)) begin
          state_d = strap_pkg::S_PLL;
        end
      end
      strap_pkg::S_PLL: begin
        if (expired(cnt_q, PLL_LIM)) begin
          state_d = strap_pkg::S_BB;
        end
      end
      strap_pkg::S_BB: begin
        if (expired(cnt_q, BB_LIM)) begin
          state_d = strap_pkg::S_RUN;
        end
      end
      strap_pkg::S_RUN: begin
        state_d = strap_pkg::S_RUN;
      end
      default: begin
        state_d = strap_pkg::S_START;
      end
    endcase
  end

  assign cnt_d = (state_d != state_q || state_q == strap_pkg::S_RUN) ? '0 : cnt_q + 1'b1;

  // autonomous transmitter control; SPI modes leave it to the partner
  // continuous wave stays on
  // The level is held during a pause so the transmitter stays in step with the frozen timer.
  assign tx_d = pause ? tx_q :
                (state_q == strap_pkg::S_BB) || run_wave || (run_pulsed && pulse_tx);

  // phase accumulator for the clock output
  // Edges sit on the system clock grid: periods jitter by one cycle, the average is exact.
  assign clk_run = init_done_q && (mode_q == strap_pkg::MODE_SPI_CLK);
  assign nco_sum = {1'b0, nco_q} + strap_pkg::NCO_STEP;
  assign nco_d   = !clk_run ? 8'h00 :
                   (nco_sum >= strap_pkg::NCO_MOD) ? 8'(nco_sum - strap_pkg::NCO_MOD) :
                   nco_sum[7:0];

  // soft reset restarts the sequence
  // Soft reset wins over a pause, so a stuck chip select cannot block recovery.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_q <= strap_pkg::S_START;
      cnt_q   <= '0;
    end else if (SOFT_RESET_IN) begin
      state_q <= strap_pkg::S_START;
      cnt_q   <= '0;
    end else if (!pause) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      mode_q  <= strap_pkg::MODE_RST;
      codes_q <= '0;
    end else if (SOFT_RESET_IN) begin
      mode_q  <= strap_pkg::MODE_RST;
      codes_q <= '0;
    end else if (capture_fire) begin
      mode_q  <= codes_live.mode;
      codes_q <= codes_live;
    end
  end

  // fuse bank latched with the straps
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      fuse_q <= '0;
    end else if (SOFT_RESET_IN) begin
      fuse_q <= '0;
    end else if (capture_fire) begin
      fuse_q <= fuse_live;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      init_done_q <= 1'b0;
      spi_own_q   <= 1'b0;
    end else if (SOFT_RESET_IN) begin
      init_done_q <= 1'b0;
      spi_own_q   <= 1'b0;
    end else begin
      init_done_q <= init_done_q || (capture_fire && live_is_spi) || leave_bb;
      spi_own_q   <= spi_own_q || (capture_fire && live_is_spi) || leave_defaults;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tx_q  <= 1'b0;
      nco_q <= 8'h00;
      clk_q <= 1'b0;
    end else if (SOFT_RESET_IN) begin
      tx_q  <= 1'b0;
      nco_q <= 8'h00;
      clk_q <= 1'b0;
    end else begin
      tx_q  <= tx_d;
      nco_q <= nco_d;
      clk_q <= clk_run && (nco_d >= strap_pkg::NCO_HALF);
    end
  end

  pulse_gate #(
    .PRP_CYC (PRP_CYC)
  ) pulse_gate_i (
    .clk_in    (CLK_SYS_IN),
    .arst_n_in (ARST_N_IN),
    .enable_in (pulse_en),
    .pause_in  (pause),
    .tx_on_out (pulse_tx)
  );

  assign MODE_OUT        = mode_q;
  assign STRAP_CODES_OUT = codes_q;
  assign FUSE_OUT        = fuse_q;
  assign INIT_DONE_OUT   = init_done_q;
  assign SPI_EXT_OWN_OUT = spi_own_q;
  assign TX_EN_OUT       = tx_q;
  assign CLK96_OUT       = clk_q;

  // Checks run on the system clock and are off while the reset pin is held.
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);

  a_mode_held_run: assert property (
    (state_q == strap_pkg::S_RUN) && !SOFT_RESET_IN |=> $stable(mode_q) && $stable(codes_q))
    else $error("Mode changed after capture.");

  a_capture_mode: assert property (
    capture_fire && !SOFT_RESET_IN |=> mode_q == $past(codes_live.mode))
    else $error("Captured mode differs from strap code.");

  a_spi_quick_done: assert property (
    capture_fire && live_is_spi && !SOFT_RESET_IN
      |=> init_done_q && spi_own_q && state_q == strap_pkg::S_RUN)
    else $error("SPI mode did not end init after capture.");

  a_done_on_leave: assert property (
    $rose(init_done_q) |-> $past(state_q) inside {strap_pkg::S_CAPTURE, strap_pkg::S_BB})
    else $error("Init done set outside an init exit.");

  a_no_ext_early: assert property (
    state_q inside {strap_pkg::S_START, strap_pkg::S_SETTLE, strap_pkg::S_CAPTURE}
      |-> !spi_own_q)
    else $error("SPI handed over before capture.");

  a_wave_radiates: assert property (
    run_wave ##1 (run_wave && !SOFT_RESET_IN) |-> tx_q)
    else $error("Transmitter off in continuous wave mode.");

  a_pause_freeze: assert property (
    pause && !SOFT_RESET_IN |=> state_q == $past(state_q) && cnt_q == $past(cnt_q))
    else $error("Controller advanced while chip select low.");

  a_soft_restart: assert property (
    SOFT_RESET_IN |=> state_q == strap_pkg::S_START && !init_done_q && !spi_own_q
      && mode_q == strap_pkg::MODE_RST)
    else $error("Soft reset did not restart capture.");

  a_clk_only_mode: assert property (
    clk_q |-> mode_q == strap_pkg::MODE_SPI_CLK && init_done_q)
    else $error("Clock output active outside clock mode.");

  a_clk_toggles: assert property (
    (clk_run && !SOFT_RESET_IN) [*3] |-> ##[0:4] $changed(clk_q))
    else $error("Clock output stuck in clock mode.");

  a_spi_no_tx: assert property (
    (state_q == strap_pkg::S_RUN) && mode_q[1] && $past(state_q) == strap_pkg::S_RUN
      |-> !tx_q)
    else $error("Block drove transmitter in SPI mode.");

  a_capture_once: assert property (
    capture_fire && !SOFT_RESET_IN
      |=> state_q inside {strap_pkg::S_DEFAULTS, strap_pkg::S_RUN})
    else $error("Strap capture did not leave the capture state.");

  a_fuse_capture: assert property (
    capture_fire && !SOFT_RESET_IN |=> fuse_q == $past(fuse_live))
    else $error("Captured fuses differ from fuse inputs.");

  a_fuse_held: assert property (
    (state_q == strap_pkg::S_RUN) && !SOFT_RESET_IN |=> $stable(fuse_q))
    else $error("Fuses changed after capture.");

  a_own_after_defaults: assert property (
    state_q inside {strap_pkg::S_PLL, strap_pkg::S_BB} |-> spi_own_q)
    else $error("SPI not handed over after the defaults phase.");

  a_done_held: assert property (
    init_done_q && !SOFT_RESET_IN |=> init_done_q)
    else $error("Init done dropped without a reset.");

  a_pulsed_tx_follow: assert property (
    run_pulsed && !pause && !SOFT_RESET_IN |=> tx_q == $past(pulse_tx))
    else $error("Transmitter does not follow the pulse gate.");

endmodule

// File: verif/spi_host_model.sv
// Purpose: Behavioural stand-in for the optional external SPI controller.
// Assumes: Only the chip-select pad reaches the strap sampler.
// Notes: Select idles high, because a low select would stall the controller.
module spi_host_model (
  input  wire logic clk_in,
  output logic      cs_n_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial cs_n_out = 1'b1;

  task automatic own_bus(input int cycles);
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (cycles) @(negedge clk_in);
    cs_n_out = 1'b1;
  endtask
endmodule

// File: verif/radar_mode_strap_sampler_bench.sv
// Purpose: Self-checking bench for strap capture, mode selection and init.
// Assumes: Shortened baseband settle and pulse period parameters.
// Notes: Pads drive thermometer levels; each field gets a different level.
module radar_mode_strap_sampler_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned BB_CYC  = 50;
  localparam int unsigned PRP_CYC = 300;
  localparam int SPI_INIT_CYC  = strap_pkg::SETTLE_CYC + 2;
  localparam int AUTO_INIT_CYC = SPI_INIT_CYC + strap_pkg::DEFAULTS_CYC + strap_pkg::PLL_CYC + BB_CYC;
  localparam int PULSED_ON     = 4 * strap_pkg::PULSE_ON_CYC;

  logic                         clk_sys;
  logic                         arst_n;
  logic                         soft_reset;
  logic                         spi_cs_n;
  strap_pkg::strap_pads_t       strap_pads;
  logic [strap_pkg::FUSE_W-1:0] fuse;
  strap_pkg::op_mode_t          mode;
  strap_pkg::strap_codes_t      codes;
  logic [strap_pkg::FUSE_W-1:0] fuse_seen;
  logic                         init_done;
  logic                         ext_own;
  logic                         tx_en;
  logic                         clk96;
  int                           miscompares = 0;
  int                           compares = 0;

  radar_mode_strap_sampler #(
    .BB_SETTLE_CYC (BB_CYC),
    .PRP_CYC       (PRP_CYC)
  ) radar_mode_strap_sampler_i (
    .CLK_SYS_IN      (clk_sys),
    .ARST_N_IN       (arst_n),
    .SOFT_RESET_IN   (soft_reset),
    .SPI_CS_N_IN     (spi_cs_n),
    .STRAP_PADS_IN   (strap_pads),
    .FUSE_IN         (fuse),
    .MODE_OUT        (mode),
    .STRAP_CODES_OUT (codes),
    .FUSE_OUT        (fuse_seen),
    .INIT_DONE_OUT   (init_done),
    .SPI_EXT_OWN_OUT (ext_own),
    .TX_EN_OUT       (tx_en),
    .CLK96_OUT       (clk96)
  );

  spi_host_model spi_host_model_i (
    .clk_in   (clk_sys),
    .cs_n_out (spi_cs_n)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_count(input string what, input int exp, input int got, input int tol);
    compares++;
    if (got < exp - tol || got > exp + tol) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Pad comparators read as a thermometer: the code is the count of ones.
  function automatic strap_pkg::pad_level_t therm(input logic [1:0] c);
    return {c == 2'h3, c >= 2'h2, c != 2'h0};
  endfunction

  task automatic set_pads(input logic [1:0] m);
    strap_pads = '{freq: therm(m + 2'h3), hold: therm(m + 2'h2),
                   thresh: therm(m + 2'h1), mode: therm(m)};
    fuse = {4{2'h1, m}};
  endtask

  task automatic do_reset();
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk_val("mode_in_reset", 16'h0000, 16'(mode));
    chk_val("done_in_reset", 16'h0000, 16'(init_done));
    chk_val("own_in_reset", 16'h0000, 16'(ext_own));
    arst_n = 1'b1;
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while (init_done !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 8000) begin
        miscompares++;
        end_of_test();
      end
    end
  endtask

  task automatic run_mode(input logic [1:0] m);
    int n;
    int txn;
    int rises;
    logic prev;
    logic [7:0] exp_codes;
    logic [15:0] exp_fuse;
    int exp_tx;
    exp_codes = {m + 2'h3, m + 2'h2, m + 2'h1, m};
    set_pads(m);
    exp_fuse = fuse;
    do_reset();
    wait_done(n);
    if (m[1]) begin
      chk_count("spi_init_cycles", SPI_INIT_CYC, n, 4);
    end else begin
      chk_count("auto_init_cycles", AUTO_INIT_CYC, n, 4);
    end
    chk_val("mode", 16'(m), 16'(mode));
    chk_val("codes", 16'(exp_codes), 16'(codes));
    chk_val("fuse", exp_fuse, fuse_seen);
    chk_val("ext_own", 16'h0001, 16'(ext_own));
    repeat (10) @(negedge clk_sys);
    // Scrambled pads after capture must leave every latched value alone.
    strap_pads = ~strap_pads;
    fuse = ~fuse;
    txn = 0;
    rises = 0;
    prev = clk96;
    repeat (4 * PRP_CYC) begin
      @(negedge clk_sys);
      if (tx_en === 1'b1) txn++;
      if (clk96 === 1'b1 && prev === 1'b0) rises++;
      prev = clk96;
    end
    exp_tx = (m == 2'h0) ? 4 * PRP_CYC : ((m == 2'h1) ? PULSED_ON : 0);
    chk_val("codes_held", 16'(exp_codes), 16'(codes));
    chk_val("fuse_held", exp_fuse, fuse_seen);
    chk_val("mode_held", 16'(m), 16'(mode));
    chk_count("tx_on_cycles", exp_tx, txn, 0);
    chk_count("clk96_rises", m == 2'h2 ? 576 : 0, rises, 1);
  endtask

  task automatic soft_recapture();
    int n;
    set_pads(2'h3);
    @(negedge clk_sys);
    soft_reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_val("mode_soft", 16'h0000, 16'(mode));
    chk_val("done_soft", 16'h0000, 16'(init_done));
    chk_val("own_soft", 16'h0000, 16'(ext_own));
    chk_val("tx_soft", 16'h0000, 16'(tx_en));
    soft_reset = 1'b0;
    wait_done(n);
    chk_count("soft_init_cycles", SPI_INIT_CYC, n, 4);
    chk_val("mode_recapt", 16'h0003, 16'(mode));
  endtask

  task automatic paused_capture();
    int n;
    set_pads(2'h3);
    do_reset();
    spi_host_model_i.own_bus(500);
    chk_val("ext_own_init", 16'h0000, 16'(ext_own));
    chk_val("mode_paused", 16'h0000, 16'(mode));
    wait_done(n);
    chk_count("paused_init_cycles", SPI_INIT_CYC + 500, n + 501, 6);
    chk_val("ext_own_after", 16'h0001, 16'(ext_own));
  endtask

  initial begin
    arst_n = 1'b0;
    soft_reset = 1'b0;
    set_pads(2'h0);
    for (int m = 0; m < 4; m++) begin
      run_mode(2'(m));
    end
    run_mode(2'h1);
    soft_recapture();
    paused_capture();
    end_of_test();
  end
endmodule
